/* File: design/dol_pkg.sv */
// Constants, state codes and pad carrier for the deserializer output and lock control
package dol_pkg;

  // ********************************************************************
  // Register map on APB (byte addresses)
  // ********************************************************************
  localparam logic [7:0]  CTRL_ADDR    = 8'h00;
  localparam logic [7:0]  STAT_ADDR    = 8'h04;
  localparam logic [7:0]  WORD_ADDR    = 8'h08;
  localparam logic [7:0]  ERR_ADDR     = 8'h0C;
  localparam int          CTRL_RUN_BIT = 0;
  localparam logic        CTRL_RUN_RST = 1'b1;
  localparam int          STAT_LOCK    = 0;
  localparam int          STAT_SLEEP   = 1;
  localparam int          STAT_REF     = 2;

  // ********************************************************************
  // Serial frame layout: start 1, ten data bits LSB first, stop 0
  // ********************************************************************
  localparam int          WORD_W       = 10;
  localparam logic [3:0]  START_POS    = 4'h0;
  localparam logic [3:0]  ENTRY_POS    = 4'h1;
  localparam logic [3:0]  DATA_FIRST   = 4'h1;
  localparam logic [3:0]  DATA_LAST    = 4'hA;
  localparam logic [3:0]  FRAME_LAST   = 4'hB;
  localparam logic [3:0]  HALF_BITS    = 4'h6;
  localparam logic [3:0]  LOCK_FRAMES  = 4'h4;
  localparam logic [7:0]  REF_TIMEOUT  = 8'h40;
  localparam logic [7:0]  ERR_MAX      = 8'hFF;

  // ********************************************************************
  // Types
  // ********************************************************************
  typedef enum logic [1:0] {
    ST_HUNT  = 2'b01,
    ST_FRAME = 2'b10
  } dol_state_t;

  typedef struct packed {
    logic [9:0] word;
    logic       word_oe;
    logic       clk;
    logic       clk_oe;
    logic       lock_n;
    logic       lock_oe;
  } dol_pads_t;

endpackage

/* File: design/dol_top.sv */
// Output, strobe and lock control of the serial-to-parallel receiver, APB control port
//
// Operation
// - Strobe edge select high times word to rising clock edge, low to falling.
// - Sleep stops recovery loop and floats word, clock and lock outputs.
// - Lock indicator low once loop locked to stream framing, high otherwise.
// - Output enable low floats word and clock while powered.
// - While lock indicator high, word and clock outputs stay floating.
// - Awake device always drives lock indicator, even with output enable low.
// - Awake, enabled and locked: clock toggles and word drives received data.
// - Recovered clock runs at word rate and strobes the output word.
//
// Our own choices: register access over APB and the register addresses.
module dol_top (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Serial link and loop reference
  input  wire logic              serial_in_pos,
  input  wire logic              serial_in_neg,
  input  wire logic              loop_reference_clock,
  // Control pins
  input  wire logic              sleep_n,
  input  wire logic              out_enable,
  input  wire logic              strobe_edge_select,
  // Parallel word, recovered clock and lock indicator with enables
  output dol_pkg::dol_pads_t     pads
);

  // ********************************************************************
  // Reference clock watchdog
  // ********************************************************************
  logic       ref_q;
  logic       ref_prev;
  logic [7:0] ref_timer;
  logic [7:0] next_ref_timer;
  logic       ref_alive;

  // Loop may only claim lock while the reference is toggling
  assign ref_alive = (ref_timer != dol_pkg::REF_TIMEOUT);

  // Restart on each reference edge, saturate at the timeout
  always_comb
  begin
    if (ref_q != ref_prev)
      next_ref_timer = 8'h00;
    else if (ref_timer == dol_pkg::REF_TIMEOUT)
      next_ref_timer = ref_timer;
    else
      next_ref_timer = ref_timer + 8'h01;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ref_q     <= 1'b0;
      ref_prev  <= 1'b0;
      ref_timer <= dol_pkg::REF_TIMEOUT;
    end
    else
    begin
      ref_q     <= loop_reference_clock;
      ref_prev  <= ref_q;
      ref_timer <= next_ref_timer;
    end
  end

  // ********************************************************************
  // Frame recovery and lock
  // ********************************************************************
  dol_pkg::dol_state_t state;
  dol_pkg::dol_state_t next_state;
  logic [3:0]          cnt;
  logic [3:0]          next_cnt;
  logic                prev_bit;
  logic [9:0]          shreg;
  logic [9:0]          next_shreg;
  logic [9:0]          rx_word;
  logic [9:0]          next_rx_word;
  logic                frame_bad;
  logic                next_frame_bad;
  logic [3:0]          good_cnt;
  logic [3:0]          next_good_cnt;
  logic                locked;
  logic                next_locked;
  logic [7:0]          err_cnt;
  logic [7:0]          next_err_cnt;
  logic                ctrl_run;
  logic                loop_go;
  logic                bit_val;
  logic                bit_bad;
  logic                bad_now;

  // Equal legs of the pair carry no bit; that spoils the frame
  assign bit_val = serial_in_pos & ~serial_in_neg;
  assign bit_bad = (serial_in_pos == serial_in_neg);
  assign loop_go = sleep_n & ctrl_run & ref_alive;
  assign bad_now = frame_bad | bit_bad | ((cnt == dol_pkg::START_POS) & ~bit_val);

  // Hunt for the 0-to-1 embedded clock edge, then check every frame
  always_comb
  begin
    next_state     = state;
    next_cnt       = cnt;
    next_shreg     = shreg;
    next_rx_word   = rx_word;
    next_frame_bad = frame_bad;
    next_good_cnt  = good_cnt;
    next_locked    = locked;
    next_err_cnt   = err_cnt;
    if (!loop_go)
    begin
      // Loop halted: no lock survives sleep or a lost reference
      next_state     = dol_pkg::ST_HUNT;
      next_cnt       = dol_pkg::START_POS;
      next_frame_bad = 1'b0;
      next_good_cnt  = 4'h0;
      next_locked    = 1'b0;
    end
    else
    begin
      unique case (state)
        dol_pkg::ST_HUNT:
        begin
          if (!prev_bit && bit_val && !bit_bad)
          begin
            next_state     = dol_pkg::ST_FRAME;
            next_cnt       = dol_pkg::ENTRY_POS;
            next_frame_bad = 1'b0;
          end
        end
        dol_pkg::ST_FRAME:
        begin
          next_cnt       = cnt + 4'h1;
          next_frame_bad = bad_now;
          if (cnt >= dol_pkg::DATA_FIRST && cnt <= dol_pkg::DATA_LAST)
            next_shreg = {bit_val, shreg[9:1]};
          if (cnt == dol_pkg::FRAME_LAST)
          begin
            next_cnt       = dol_pkg::START_POS;
            next_frame_bad = 1'b0;
            if (!bad_now && !bit_val)
            begin
              // Lock after enough clean frames in a row
              next_rx_word  = shreg;
              next_good_cnt = (good_cnt == dol_pkg::LOCK_FRAMES) ? good_cnt
                                                                 : good_cnt + 4'h1;
              next_locked   = (next_good_cnt == dol_pkg::LOCK_FRAMES);
            end
            else
            begin
              // One broken frame drops lock and restarts the hunt
              next_state    = dol_pkg::ST_HUNT;
              next_good_cnt = 4'h0;
              next_locked   = 1'b0;
              next_err_cnt  = (err_cnt == dol_pkg::ERR_MAX) ? err_cnt : err_cnt + 8'h01;
            end
          end
        end
        default:
        begin
          next_state = dol_pkg::ST_HUNT;
          next_cnt   = dol_pkg::START_POS;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state     <= dol_pkg::ST_HUNT;
      cnt       <= dol_pkg::START_POS;
      prev_bit  <= 1'b1;
      shreg     <= 10'h000;
      rx_word   <= 10'h000;
      frame_bad <= 1'b0;
      good_cnt  <= 4'h0;
      locked    <= 1'b0;
      err_cnt   <= 8'h00;
    end
    else
    begin
      state     <= next_state;
      cnt       <= next_cnt;
      prev_bit  <= bit_val;
      shreg     <= next_shreg;
      rx_word   <= next_rx_word;
      frame_bad <= next_frame_bad;
      good_cnt  <= next_good_cnt;
      locked    <= next_locked;
      err_cnt   <= next_err_cnt;
    end
  end

  // ********************************************************************
  // Output pads
  // ********************************************************************
  dol_pkg::dol_pads_t next_pads;
  logic               drive;
  logic               strobe;

  // Word moves on the clock edge opposite the selected one, so it is stable there
  assign drive  = sleep_n & out_enable & next_locked;
  assign strobe = (next_state == dol_pkg::ST_FRAME) &&
                  (strobe_edge_select ? (next_cnt == dol_pkg::HALF_BITS)
                                      : (next_cnt == dol_pkg::START_POS));

  always_comb
  begin
    next_pads         = pads;
    next_pads.lock_oe = sleep_n;
    next_pads.lock_n  = ~next_locked;
    next_pads.clk     = (next_state == dol_pkg::ST_FRAME) &&
                        (next_cnt < dol_pkg::HALF_BITS);
    next_pads.clk_oe  = drive;
    next_pads.word_oe = drive;
    if (strobe)
      next_pads.word = next_rx_word;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pads <= '{word: 10'h000, word_oe: 1'b0, clk: 1'b0, clk_oe: 1'b0,
                lock_n: 1'b1, lock_oe: 1'b0};
    else
      pads <= next_pads;
  end

  // ********************************************************************
  // APB slave: one wait state, registered answer
  // ********************************************************************
  logic        next_pready;
  logic        next_pslverr;
  logic [31:0] next_prdata;
  logic        next_ctrl_run;
  logic        access;

  function automatic logic addr_known(input logic [7:0] a);
    addr_known = (a == dol_pkg::CTRL_ADDR) || (a == dol_pkg::STAT_ADDR) ||
                 (a == dol_pkg::WORD_ADDR) || (a == dol_pkg::ERR_ADDR);
  endfunction

  assign access = psel & penable & pready;

  // Read data is captured as pready rises, writes land on the completing edge
  always_comb
  begin
    next_pready   = psel & penable & ~pready;
    next_pslverr  = next_pready & ~addr_known(paddr);
    next_prdata   = 32'h0000_0000;
    next_ctrl_run = ctrl_run;
    if (next_pready && !pwrite)
    begin
      unique case (paddr)
        dol_pkg::CTRL_ADDR: next_prdata[dol_pkg::CTRL_RUN_BIT] = ctrl_run;
        dol_pkg::STAT_ADDR:
        begin
          next_prdata[dol_pkg::STAT_LOCK]  = locked;
          next_prdata[dol_pkg::STAT_SLEEP] = ~sleep_n;
          next_prdata[dol_pkg::STAT_REF]   = ref_alive;
        end
        dol_pkg::WORD_ADDR: next_prdata[9:0] = rx_word;
        dol_pkg::ERR_ADDR:  next_prdata[7:0] = err_cnt;
        default:            next_prdata = 32'h0000_0000;
      endcase
    end
    if (access && pwrite && paddr == dol_pkg::CTRL_ADDR)
      next_ctrl_run = pwdata[dol_pkg::CTRL_RUN_BIT];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready   <= 1'b0;
      pslverr  <= 1'b0;
      prdata   <= 32'h0000_0000;
      ctrl_run <= dol_pkg::CTRL_RUN_RST;
    end
    else
    begin
      pready   <= next_pready;
      pslverr  <= next_pslverr;
      prdata   <= next_prdata;
      ctrl_run <= next_ctrl_run;
    end
  end

  // ********************************************************************
  // Assertions
  // ********************************************************************
  strobe_edge_a: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(pads.word) |-> $changed(pads.clk) && (pads.clk != $past(strobe_edge_select)))
    else $error("Word changed away from the opposite strobe edge");

  sleep_float_a: assert property (@(posedge pclk) disable iff (!presetn)
    $past(!sleep_n) |-> !pads.word_oe && !pads.clk_oe && !pads.lock_oe && !locked)
    else $error("Outputs driven or lock held during sleep");

  lock_level_a: assert property (@(posedge pclk) disable iff (!presetn)
    $past(sleep_n) && $past(presetn) |->
      pads.lock_oe && (pads.lock_n == !locked) && (!locked || $past(ref_alive)))
    else $error("Lock indicator does not follow lock state");

  oe_low_a: assert property (@(posedge pclk) disable iff (!presetn)
    $past(sleep_n && !out_enable) |-> !pads.word_oe && !pads.clk_oe && pads.lock_oe)
    else $error("Word or clock driven with output enable low");

  unlock_float_a: assert property (@(posedge pclk) disable iff (!presetn)
    pads.lock_n |-> !pads.word_oe && !pads.clk_oe)
    else $error("Word or clock driven while not locked");

  active_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
    $past(sleep_n && out_enable) && locked |-> pads.word_oe && pads.clk_oe)
    else $error("Outputs floating while enabled and locked");

  clk_period_a: assert property (@(posedge pclk) disable iff (!presetn || !loop_go)
    $rose(pads.clk) && locked |-> pads.clk [*6] ##1 !pads.clk [*6] ##1 (pads.clk || !locked))
    else $error("Recovered clock not at word rate");

  first_lock_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(locked) |-> $past(good_cnt) == (dol_pkg::LOCK_FRAMES - 4'h1) && $past(pads.lock_n))
    else $error("Lock claimed before enough clean frames");

endmodule

/* File: test/dol_ser_model.sv */
// Behavioural serializer model driving the receiver's differential link
module dol_ser_model (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Control from the bench
  input  wire logic       run,
  input  wire logic       sync_req,
  input  wire logic       bad,
  input  wire logic [9:0] word,
  // Status and link
  output logic            sync_busy,
  output logic            pos,
  output logic            neg
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************
  // Frame generator
  // ****************
  localparam logic [9:0] SYNC_WORD = 10'h000;
  logic [3:0]  bit_i;
  logic [10:0] syncs;
  logic [9:0]  fw;
  logic        odd;
  logic        spoil;
  logic        b;
  // Sync symbols go out while requested and until 1024 were sent
  assign sync_busy = sync_req || (syncs < 11'h400);
  // Line level for the current frame position
  assign b = (bit_i == 4'h0) ? 1'b1 : (bit_i == 4'hB) ? 1'b0 : fw[bit_i - 4'h1];
  // One bit per edge: start 1, data LSB first, stop 0; idle sends 0
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      bit_i <= 4'h0;
      syncs <= 11'h0;
      odd   <= 1'b0;
      spoil <= 1'b0;
      pos   <= 1'b0;
      neg   <= 1'b1;
    end
    else
    begin
      // A request waits until its frame has carried the illegal bit
      if (bad)
        spoil <= 1'b1;
      else if (run && bit_i == 4'h5)
        spoil <= 1'b0;
      if (sync_req)
        syncs <= 11'h0;
      else if (run && bit_i == 4'hB && syncs < 11'h400)
        syncs <= syncs + 11'h1;
      if (bit_i == 4'h0)
        fw <= sync_busy ? SYNC_WORD : (odd ? ~word : word);
      // A spoiled frame carries one illegal bit, both lines high
      pos   <= run & ((spoil && bit_i == 4'h5) | b);
      neg   <= ~run | (spoil && bit_i == 4'h5) | ~b;
      bit_i <= (!run || bit_i == 4'hB) ? 4'h0 : bit_i + 4'h1;
      if (run && bit_i == 4'hB)
      begin
        odd   <= ~odd;
      end
    end
endmodule

/* File: test/testbench.sv */
// Self-checking bench for the receiver output and lock control
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************
  // Signals and parts
  // ****************
  logic               pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0]         paddr;
  logic [31:0]        pwdata, prdata, rd;
  logic               pos, neg, refc, ref_on, run, sync, bad, busy, sleep_n, out_en, sel, pc;
  logic [9:0]         w, pw;
  dol_pkg::dol_pads_t pads;
  int                 failures, samples_checked, per, cnt, n_r, n_f, r0, f0, rc, n;
  dol_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serial_in_pos(pos), .serial_in_neg(neg),
    .loop_reference_clock(refc), .sleep_n(sleep_n), .out_enable(out_en),
    .strobe_edge_select(sel), .pads(pads));
  dol_ser_model i_ser (.pclk(pclk), .presetn(presetn), .run(run), .sync_req(sync),
    .bad(bad), .word(w), .sync_busy(busy), .pos(pos), .neg(neg));
  // Clock of 4 ns
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // Reference runs at an eighth of pclk, well under the half rate limit
  always @(posedge pclk)
  begin
    rc <= rc + 1;
    if (ref_on && rc[1:0] == 2'h3)
      refc <= ~refc;
  end
  // Strobe period and on which clock edge the word changes
  always @(posedge pclk)
  begin
    pc  <= pads.clk;
    pw  <= pads.word;
    cnt <= (pads.clk && !pc) ? 1 : cnt + 1;
    if (pads.clk && !pc)
      per <= cnt;
    if (pads.word !== pw && pads.clk && !pc)
      n_r <= n_r + 1;
    if (pads.word !== pw && !pads.clk && pc)
      n_f <= n_f + 1;
  end
  // ****************
  // Tasks
  // ****************
  task end_of_test;
    $display("checked %0d, failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task chk_val(input logic [31:0] g, input logic [31:0] e, input string m);
    samples_checked++;
    if (g !== e)
    begin
      failures++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task chk_bit(input logic g, input logic e, input string m);
    chk_val({31'h0, g}, {31'h0, e}, m);
  endtask
  // Setup, then access held until pready is sampled high
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Wait states are the slave's; only the watchdog ends a stuck access
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd      = prdata;
    er      = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd_chk(input logic [7:0] a, input logic [31:0] e, input string m);
    apb(1'b0, a, 32'h0);
    chk_val(rd, e, m);
  endtask
  task pads_oe(input logic l, input logic d, input string m);
    chk_bit(pads.lock_oe, l, m);
    chk_bit(pads.word_oe, d, m);
    chk_bit(pads.clk_oe, d, m);
  endtask
  task wait_lock(input logic v, input string m);
    n = 0;
    while (pads.lock_n !== v && n < 400)
    begin
      @(posedge pclk);
      n++;
    end
    chk_bit(pads.lock_n, v, m);
  endtask
  // Word must change only on the strobe edge opposite to the selected one
  task phase(input logic s);
    sel <= s;
    repeat (30) @(posedge pclk);
    r0 = n_r;
    f0 = n_f;
    repeat (60) @(posedge pclk);
    chk_bit(s ? (n_r == r0) : (n_f == f0), 1'b1, "word on strobe edge");
    chk_bit(s ? (n_f > f0) : (n_r > r0), 1'b1, "word moves");
    chk_val(per, 32'hC, "clock period");
    chk_bit(pads.word === w || pads.word === ~w, 1'b1, "word data");
  endtask
  // ****************
  // Main sequence
  // ****************
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata, run, sync, bad, refc} = '0;
    {sleep_n, out_en, sel, ref_on} = 4'hF;
    {failures, samples_checked, per, cnt, n_r, n_f, rc} = '0;
    {pc, pw, w} = {1'b0, 10'h0, 10'h2A5};
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    pads_oe(1'b1, 1'b0, "boot enables");
    chk_bit(pads.lock_n, 1'b1, "boot lock");
    rd_chk(dol_pkg::CTRL_ADDR, 32'h1, "ctrl reset");
    rd_chk(dol_pkg::ERR_ADDR, 32'h0, "errors reset");
    apb(1'b1, 8'h10, 32'hFFFFFFFF);
    chk_bit(er, 1'b1, "unmapped");
    apb(1'b1, dol_pkg::STAT_ADDR, 32'hFFFFFFFF);
    run  <= 1'b1;
    sync <= 1'b1;
    wait_lock(1'b0, "first lock");
    repeat (2) @(posedge pclk);
    pads_oe(1'b1, 1'b1, "locked enables");
    rd_chk(dol_pkg::STAT_ADDR, 32'h5, "status locked");
    sync <= 1'b0;
    n = 0;
    while (busy && n < 14000)
    begin
      @(posedge pclk);
      n++;
    end
    chk_bit(busy, 1'b0, "sync run ended");
    phase(1'b1);
    phase(1'b0);
    apb(1'b0, dol_pkg::WORD_ADDR, 32'h0);
    chk_bit(rd === {22'h0, w} || rd === {22'h0, ~w}, 1'b1, "word register");
    out_en <= 1'b0;
    repeat (3) @(posedge pclk);
    pads_oe(1'b1, 1'b0, "outputs off");
    chk_bit(pads.lock_n, 1'b0, "lock kept");
    out_en <= 1'b1;
    bad    <= 1'b1;
    @(posedge pclk);
    bad    <= 1'b0;
    wait_lock(1'b1, "bad frame");
    repeat (2) @(posedge pclk);
    pads_oe(1'b1, 1'b0, "unlocked float");
    rd_chk(dol_pkg::ERR_ADDR, 32'h1, "error count");
    sync <= 1'b1;
    @(posedge pclk);
    sync <= 1'b0;
    wait_lock(1'b0, "relock");
    sleep_n <= 1'b0;
    repeat (3) @(posedge pclk);
    pads_oe(1'b0, 1'b0, "sleep float");
    rd_chk(dol_pkg::STAT_ADDR, 32'h6, "status asleep");
    sleep_n <= 1'b1;
    wait_lock(1'b0, "wake lock");
    apb(1'b1, dol_pkg::CTRL_ADDR, 32'h0);
    repeat (3) @(posedge pclk);
    chk_bit(pads.lock_n, 1'b1, "halted");
    rd_chk(dol_pkg::CTRL_ADDR, 32'h0, "ctrl write");
    apb(1'b1, dol_pkg::CTRL_ADDR, 32'h1);
    wait_lock(1'b0, "run lock");
    ref_on <= 1'b0;
    repeat (90) @(posedge pclk);
    chk_bit(pads.lock_n, 1'b1, "no reference");
    rd_chk(dol_pkg::STAT_ADDR, 32'h0, "status no ref");
    end_of_test;
  end
  // Watchdog well beyond the two sync runs
  initial
  begin
    #(4 * 60000);
    failures++;
    end_of_test;
  end
endmodule
